// file: hdl/scsi_interrupt_status_mask.sv
// SCSI interrupt status, mask and interrupt request logic
//
// Summary of operation
// - Mask register one holds timeout, general and handshake enables; clear masks; resets zero.
// - Reading status zero returns all latched conditions regardless of enables.
// - Reading status zero clears only bits shown; later events stay pending.
// - Bit 7: initiator phase mismatch on request, or target sees attention.
// - Bit 6: arbitration-only or arbitration-and-selection sequence finished.
// - Bits 5,4: selected/reselected only with response enable and own ID match.
// - Bit 3 gross error: FIFO underflow or overflow.
// - Gross error also for target offset underflow, offset overflow, initiator phase change, residual data.
// - Bit 2: initiator unexpected disconnect; any disconnect in low-level mode.
// - Disconnect bit also set on selection timeout.
// - Bit 1: edge-detected bus reset, one interrupt per assertion.
// - Bit 0: receive parity error, only with parity checking enabled.
// - Parity always generated on sent data.
// - Status one bit 2: selection or reselection timeout.
// - Status one bit 1: general-purpose timer expired.
// - Status one bit 0: handshake timer expired.
// - Reading status one clears and returns it regardless of enables.
// - Interrupt request holds until status read; masking does not drop it.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module scsi_interrupt_status_mask
    import scsi_irq_pkg::*;
#(
    parameter int ID_W = 4                                  // Bus ID width
) (
    input  wire logic                        i_sys_clk,          // Clock, 25 MHz
    input  wire logic                        i_rst,              // Async reset, active high
    input  wire logic [scsi_irq_pkg::ADDR_W-1:0] i_addr,         // Register address
    input  wire logic [scsi_irq_pkg::DATA_W-1:0] i_wdata,        // Write data
    input  wire logic                        i_wr,               // Write strobe
    input  wire logic                        i_rd,               // Read strobe
    output logic      [scsi_irq_pkg::DATA_W-1:0] o_rdata,        // Read data, cycle after strobe
    output logic                             o_irq,              // Interrupt request, active high
    input  wire logic [ID_W-1:0]             i_own_id,           // Own bus ID
    input  wire logic [ID_W-1:0]             i_response_id,      // ID held in response ID reg
    input  wire logic                        i_phase_req,        // Request seen, initiator
    input  wire logic                        i_phase_match,      // Bus phase equals expected
    input  wire logic                        i_atn,              // Attention level, target
    input  wire logic                        i_arb_done,         // Arbitration sequence done
    input  wire logic                        i_sel_seen,         // Selection by another device
    input  wire logic                        i_rsl_seen,         // Reselection by another device
    input  wire logic                        i_fifo_underflow,   // FIFO read while empty
    input  wire logic                        i_fifo_overflow,    // FIFO overwritten
    input  wire logic                        i_offset_underflow, // Ack with zero offset
    input  wire logic                        i_offset_overflow,  // Max offset exceeded
    input  wire logic                        i_phase_chg_offset, // Phase change, offset open
    input  wire logic                        i_residual_start,   // Start with residual data
    input  wire logic                        i_disconnect,       // Target left the bus
    input  wire logic                        i_disc_expected,    // Disconnect was expected
    input  wire logic                        i_bus_reset,        // Reset line level
    input  wire logic                        i_rx_strobe,        // Received data byte valid
    input  wire logic [7:0]                  i_rx_data,          // Received data byte
    input  wire logic                        i_rx_parity,        // Received odd parity bit
    input  wire logic [7:0]                  i_tx_data,          // Data byte to send
    output logic                             o_tx_parity,        // Generated odd parity bit
    input  wire logic                        i_sel_timeout,      // Selection timer expired
    input  wire logic                        i_gen_timeout,      // General timer expired
    input  wire logic                        i_hs_timeout        // Handshake timer expired
);
    import scsi_irq_pkg::*;

    // Elaboration-time guard; the ID compare is built for 1 to 8 bits
    if (ID_W < 1 || ID_W > 8) begin : g_id_w_check
        $error("ID_W out of range");
    end

    logic [7:0]           mask0_reg;
    logic [ST1_WIDTH-1:0] mask1_reg;
    logic [7:0]           ctl_reg;
    logic [7:0]           stat0_reg;
    logic [7:0]           stat0_next;
    logic [ST1_WIDTH-1:0] stat1_reg;
    logic [ST1_WIDTH-1:0] stat1_next;
    logic                 bus_reset_reg;
    logic [7:0]           ev0;
    logic [ST1_WIDTH-1:0] ev1;
    logic                 rd0;
    logic                 rd1;
    logic                 initiator;
    logic                 id_match;

    function automatic logic odd_parity(input logic [7:0] d);
        odd_parity = ~(^d);
    endfunction : odd_parity

    assign rd0       = i_rd && (i_addr == ADDR_STATUS_0);
    assign rd1       = i_rd && (i_addr == ADDR_STATUS_1);
    assign initiator = ~ctl_reg[CTL_TARGET];
    assign id_match  = (i_response_id == i_own_id);

    always_comb begin
        ev0 = 8'h00;
        ev0[ST0_MISMATCH]   = (initiator && i_phase_req && !i_phase_match)
                            || (!initiator && i_atn);
        ev0[ST0_COMPLETE]   = i_arb_done;
        ev0[ST0_SELECTED]   = i_sel_seen && ctl_reg[CTL_SEL_RESP_EN] && id_match;
        ev0[ST0_RESELECTED] = i_rsl_seen && ctl_reg[CTL_RSL_RESP_EN] && id_match;
        ev0[ST0_GROSS]      = i_fifo_underflow || i_fifo_overflow
                            || (!initiator && i_offset_underflow) || i_offset_overflow
                            || (initiator && i_phase_chg_offset) || i_residual_start;
        ev0[ST0_DISCONNECT] = (i_disconnect && (ctl_reg[CTL_LOW_LEVEL]
                            || (initiator && !i_disc_expected)))
                            || i_sel_timeout;
        ev0[ST0_BUS_RESET]  = i_bus_reset && !bus_reset_reg;
        ev0[ST0_PARITY]     = i_rx_strobe && ctl_reg[CTL_PARITY_EN]
                            && (odd_parity(i_rx_data) != i_rx_parity);
        ev1 = '0;
        ev1[ST1_SEL_TIMEOUT] = i_sel_timeout;
        ev1[ST1_GEN_TIMER]   = i_gen_timeout;
        ev1[ST1_HANDSHAKE]   = i_hs_timeout;
    end

    // New events win over the read clear, so a stacked condition survives
    assign stat0_next = (rd0 ? 8'h00 : stat0_reg) | ev0;
    assign stat1_next = (rd1 ? '0 : stat1_reg) | ev1;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            stat0_reg <= 8'h00;
            stat1_reg <= '0;
        end else begin
            stat0_reg <= stat0_next;
            stat1_reg <= stat1_next;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            bus_reset_reg <= 1'b0;
        end else begin
            bus_reset_reg <= i_bus_reset;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            mask0_reg <= MASK_0_RESET;
            mask1_reg <= MASK_1_RESET;
            ctl_reg   <= CONTROL_RESET;
        end else if (i_wr) begin
            case (i_addr)
                ADDR_MASK_0: mask0_reg <= i_wdata;
                ADDR_MASK_1: mask1_reg <= i_wdata[ST1_WIDTH-1:0];
                ADDR_CONTROL: ctl_reg  <= i_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= READ_UNMAPPED;
        end else if (i_rd) begin
            case (i_addr)
                ADDR_MASK_0:   o_rdata <= mask0_reg;
                ADDR_MASK_1:   o_rdata <= {5'h00, mask1_reg};
                ADDR_STATUS_0: o_rdata <= stat0_reg;
                ADDR_STATUS_1: o_rdata <= {5'h00, stat1_reg};
                ADDR_CONTROL:  o_rdata <= ctl_reg;
                default:       o_rdata <= READ_UNMAPPED;
            endcase
        end else begin
            o_rdata <= READ_UNMAPPED;
        end
    end

    // Latched: only a status read drops it; a later mask write cannot
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else if (|(stat0_next & mask0_reg) || |(stat1_next & mask1_reg)) begin
            o_irq <= 1'b1;
        end else if (rd0 || rd1) begin
            o_irq <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_tx_parity <= 1'b1;
        end else begin
            o_tx_parity <= odd_parity(i_tx_data);
        end
    end
endmodule : scsi_interrupt_status_mask

// file: hdl/scsi_irq_pkg.sv
// Register map, field positions and reset values of the SCSI interrupt status block
package scsi_irq_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam logic [7:0]  ADDR_MASK_0     = 8'h40;
    localparam logic [7:0]  ADDR_MASK_1     = 8'h41;
    localparam logic [7:0]  ADDR_STATUS_0   = 8'h42;
    localparam logic [7:0]  ADDR_STATUS_1   = 8'h43;
    localparam logic [7:0]  ADDR_CONTROL    = 8'h50;
    localparam logic [7:0]  MASK_0_RESET    = 8'h00;
    localparam logic [2:0]  MASK_1_RESET    = 3'h0;
    localparam logic [7:0]  CONTROL_RESET   = 8'h00;
    localparam logic [7:0]  READ_UNMAPPED   = 8'h00;
    // Status 0 bit positions
    localparam int          ST0_MISMATCH    = 7;
    localparam int          ST0_COMPLETE    = 6;
    localparam int          ST0_SELECTED    = 5;
    localparam int          ST0_RESELECTED  = 4;
    localparam int          ST0_GROSS       = 3;
    localparam int          ST0_DISCONNECT  = 2;
    localparam int          ST0_BUS_RESET   = 1;
    localparam int          ST0_PARITY      = 0;
    // Status 1 bit positions
    localparam int          ST1_SEL_TIMEOUT = 2;
    localparam int          ST1_GEN_TIMER   = 1;
    localparam int          ST1_HANDSHAKE   = 0;
    localparam int          ST1_WIDTH       = 3;
    // Control register fields
    localparam int          CTL_PARITY_EN   = 3;
    localparam int          CTL_SEL_RESP_EN = 5;
    localparam int          CTL_RSL_RESP_EN = 4;
    localparam int          CTL_LOW_LEVEL   = 0;
    localparam int          CTL_TARGET      = 1;
endpackage : scsi_irq_pkg

// file: test/scsi_interrupt_status_mask_props.sv
// Port-level properties of the SCSI interrupt status block
`timescale 1ns/1ps
module scsi_interrupt_status_mask_props
    import scsi_irq_pkg::*;
(
    input wire logic       i_sys_clk, i_rst, i_wr, i_rd, o_irq, o_tx_parity, i_phase_req, i_atn, i_arb_done,
    input wire logic       i_sel_seen, i_rsl_seen, i_fifo_underflow, i_fifo_overflow, i_offset_underflow,
    input wire logic       i_offset_overflow, i_phase_chg_offset, i_residual_start, i_disconnect, i_bus_reset,
    input wire logic       i_rx_strobe, i_sel_timeout, i_gen_timeout, i_hs_timeout,
    input wire logic [7:0] i_addr, o_rdata, i_tx_data
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    wire logic st_rd = i_rd && (i_addr == ADDR_STATUS_0 || i_addr == ADDR_STATUS_1);
    // Levels included too, so this over-approximates the causes
    wire logic ev_any = |{i_phase_req, i_atn, i_arb_done, i_sel_seen, i_rsl_seen, i_fifo_underflow, i_fifo_overflow,
        i_offset_underflow, i_offset_overflow, i_phase_chg_offset, i_residual_start, i_disconnect, i_bus_reset,
        i_rx_strobe, i_sel_timeout, i_gen_timeout, i_hs_timeout};
    property p_tx_parity; !$past(i_rst) |-> o_tx_parity == ~^$past(i_tx_data); endproperty
    a_tx_parity: assert property (p_tx_parity) else $error("tx parity wrong");
    property p_irq_fall; $fell(o_irq) |-> $past(st_rd) || $past(st_rd, 2); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without status read");
    property p_irq_mask; o_irq && i_wr && !$past(st_rd) |=> o_irq; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq dropped on write");
    property p_irq_rise; $rose(o_irq) |-> $past(ev_any) || $past(i_wr) || $past(ev_any, 2) || $past(i_wr, 2); endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    property p_idle_rdata; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside read");
    property p_st1_rsvd; $past(i_rd && i_addr == ADDR_STATUS_1) |-> o_rdata[7:3] == 5'h00; endproperty
    a_st1_rsvd: assert property (p_st1_rsvd) else $error("status one reserved bits set");
    property p_mask1_rsvd; $past(i_rd && i_addr == ADDR_MASK_1) |-> o_rdata[7:3] == 5'h00; endproperty
    a_mask1_rsvd: assert property (p_mask1_rsvd) else $error("mask one reserved bits set");
    property p_unmapped; $past(i_rd && i_addr[7:4] == 4'h6) |-> o_rdata == READ_UNMAPPED; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    c_irq_clear: cover property (o_irq ##1 !o_irq);
    c_status_seen: cover property (st_rd ##1 o_rdata != 8'h00);
    c_mask_write: cover property (o_irq && i_wr);
endmodule : scsi_interrupt_status_mask_props
bind scsi_interrupt_status_mask scsi_interrupt_status_mask_props props_u (.i_sys_clk, .i_rst, .i_wr, .i_rd, .o_irq,
    .o_tx_parity, .i_phase_req, .i_atn, .i_arb_done, .i_sel_seen, .i_rsl_seen, .i_fifo_underflow, .i_fifo_overflow,
    .i_offset_underflow, .i_offset_overflow, .i_phase_chg_offset, .i_residual_start, .i_disconnect, .i_bus_reset,
    .i_rx_strobe, .i_sel_timeout, .i_gen_timeout, .i_hs_timeout, .i_addr, .o_rdata, .i_tx_data);

// file: test/scsi_interrupt_status_mask_test.sv
// Self-checking bench for the SCSI interrupt status block
`timescale 1ns/1ps
module scsi_interrupt_status_mask_test;
    import scsi_irq_pkg::*;
    logic        i_sys_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, rd_d = 0, ok = 0, match = 0, rxp = 0, busr = 0, atn = 0;
    logic [7:0]  i_addr = 0, i_wdata = 0, rxd = 0, txd = 0, txd_q = 0, r;
    logic [3:0]  own = 4'h5, rid = 4'h5;
    logic [14:0] ev = 0;
    logic [7:0]  q[$];
    logic [7:0]  e0[15] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h08, 8'h00, 8'h08, 8'h08, 8'h08, 8'h04, 8'h01,
                            8'h04, 8'h00, 8'h00};
    int          failures = 0, checks_done = 0, cyc = 0;
    wire logic [7:0] got;
    wire logic   irq, txp;
    scsi_interrupt_status_mask dut_u (.i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata(got), .o_irq(irq),
        .i_own_id(own), .i_response_id(rid), .i_phase_req(ev[0]), .i_phase_match(match), .i_atn(atn),
        .i_arb_done(ev[1]), .i_sel_seen(ev[2]), .i_rsl_seen(ev[3]), .i_fifo_underflow(ev[4]), .i_fifo_overflow(ev[5]),
        .i_offset_underflow(ev[6]), .i_offset_overflow(ev[7]), .i_phase_chg_offset(ev[8]), .i_residual_start(ev[9]),
        .i_disconnect(ev[10]), .i_disc_expected(ok), .i_bus_reset(busr), .i_rx_strobe(ev[11]), .i_rx_data(rxd),
        .i_rx_parity(rxp), .i_tx_data(txd), .o_tx_parity(txp), .i_sel_timeout(ev[12]), .i_gen_timeout(ev[13]),
        .i_hs_timeout(ev[14]));
    initial forever #20 i_sys_clk = ~i_sys_clk;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_wr <= 1; i_addr <= a; i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 0;
        @(posedge i_sys_clk);
    endtask : wr
    // Twelve idle clocks after each read so stacked conditions settle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_rd <= 1; i_addr <= a; q.push_back(e);
        @(posedge i_sys_clk);
        i_rd <= 0; ev <= 0;
        repeat (12) @(posedge i_sys_clk);
    endtask : rd
    task automatic pulse(input logic [14:0] m);
        ev <= m;
        @(posedge i_sys_clk);
        ev <= 0;
        @(posedge i_sys_clk);
    endtask : pulse
    task automatic ichk(input logic e);
        @(negedge i_sys_clk);
        chk({7'h0, irq}, {7'h0, e});
        @(posedge i_sys_clk);
    endtask : ichk
    task results;
        $display("failures %0d checks_done %0d", failures, checks_done);
        if (failures == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    always @(negedge i_sys_clk) begin
        if (rd_d) chk(got, q.pop_front());
        if (cyc > 3) chk({7'h0, txp}, {7'h0, ~^txd_q});
    end
    always @(posedge i_sys_clk) begin
        rd_d <= i_rd;
        txd_q <= txd;
        txd <= 8'($urandom);
        cyc++;
        if (cyc > 5000) begin
            failures++;
            results();
        end
    end
    initial begin
        void'($urandom(32'hecfb70d6));
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 0;
        @(posedge i_sys_clk);
        foreach (e0[i]) if (i < 4) rd(ADDR_MASK_0 + 8'(i), 8'h00);
        r = 8'($urandom);
        wr(ADDR_MASK_1, r);
        rd(ADDR_MASK_1, {5'h0, r[2:0]});
        rd(8'h60 | (8'($urandom) & 8'h0f), READ_UNMAPPED);
        wr(ADDR_CONTROL, 8'h38);
        foreach (e0[i]) begin
            r = 8'($urandom);
            rxd <= r; rxp <= ^r;
            pulse(15'h1 << i);
            rd(ADDR_STATUS_0, e0[i]);
            rd(ADDR_STATUS_1, (i > 11) ? 8'h01 << (14 - i) : 8'h00);
        end
        busr <= 1;
        @(posedge i_sys_clk);
        rd(ADDR_STATUS_0, 8'h02);
        rd(ADDR_STATUS_0, 8'h00);
        busr <= 0; rid <= 4'ha; ok <= 1; match <= 1;
        wr(ADDR_CONTROL, 8'h30);
        pulse(15'h0c05);
        rd(ADDR_STATUS_0, 8'h00);
        wr(ADDR_CONTROL, 8'h01);
        pulse(15'h0400);
        rd(ADDR_STATUS_0, 8'h04);
        wr(ADDR_CONTROL, 8'h02);
        atn <= 1;
        pulse(15'h0040);
        atn <= 0;
        rd(ADDR_STATUS_0, 8'h88);
        wr(ADDR_CONTROL, 8'h38); rid <= own;
        pulse(15'h0008);
        ev <= 15'h0002;
        rd(ADDR_STATUS_0, 8'h10);
        rd(ADDR_STATUS_0, 8'h40);
        wr(ADDR_MASK_0, 8'h40);
        pulse(15'h0002);
        ichk(1);
        wr(ADDR_MASK_0, 8'h00);
        ichk(1);
        rd(ADDR_STATUS_0, 8'h40);
        ichk(0);
        pulse(15'h0002);
        ichk(0);
        rd(ADDR_STATUS_0, 8'h40);
        wr(ADDR_MASK_1, 8'h04);
        pulse(15'h4000);
        ichk(0);
        pulse(15'h1000);
        ichk(1);
        rd(ADDR_STATUS_1, 8'h05);
        ichk(0);
        rd(ADDR_STATUS_0, 8'h04);
        results();
    end
endmodule : scsi_interrupt_status_mask_test
